// >>> src/asfc_pkg.sv
// Shared constants and types of the sample and frame control block.
package asfc_pkg;

	// Conversion modes as set by the command datapath.
	localparam logic [1:0] ASFC_MODE_EOC    = 2'h0;
	localparam logic [1:0] ASFC_MODE_SELECT = 2'h1;

	// Serial clock rising edge on which the channel is known during a select cycle.
	localparam logic [2:0] ASFC_CHAN_SEL_EDGE = 3'h5;

	// Width of the frame edge counter and its last count before the wrap to 0.
	localparam int         ASFC_EDGE_CNT_W  = 4;
	localparam logic [3:0] ASFC_EDGE_CNT_RST = 4'h0;
	localparam logic [3:0] ASFC_EDGE_CNT_MAX = 4'hF;

	// Sampling and conversion phases, one-hot.
	typedef enum logic [2:0]
	{
		ASFC_IDLE    = 3'h1,
		ASFC_SAMPLE  = 3'h2,
		ASFC_CONVERT = 3'h4
	} asfc_phase_type;

endpackage

// >>> src/asfc_edge_detect.sv
// Edge detector for one pin input that is already synchronous to the clock.
`timescale 1ns/10ps
`default_nettype none

module asfc_edge_detect
	import asfc_pkg::*;
#(
	parameter logic RESET_LEVEL = 1'b1
)
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic pinIn,
	output logic      level,
	output logic      rise,
	output logic      fall
);

	logic prev_q;

	// The reset level equals the idle level, so no false edge comes out of reset.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			prev_q <= RESET_LEVEL;
		else
			prev_q <= pinIn;
	end

	// Edges are single-cycle pulses in the cycle the new level is first seen.
	assign level = pinIn;
	assign rise  = pinIn & ~prev_q;
	assign fall  = ~pinIn & prev_q;

endmodule

`default_nettype wire

// >>> src/asfc_sample_frame_ctrl.sv
// Sample window, conversion start, ready flag and frame gating of a serial ADC.
//
// Summary of operation
// R1 - Chip select high: start-pin low bounds sampling.
// R2 - Host asserts start after fifth select clock.
// R3 - Mode 01 early start waits for deselect.
// R4 - Start rising edge, deselected, launches conversion.
// R5 - EOC low from sample end to ready.
// R6 - EOC behaviour only in mode 00.
// R7 - Interrupt mode: falling edge marks ready data.
// R8 - Frame sync low at select: input stays off.
// R9 - Frame sync fall clears counter, enables input.
// R10 - Input off at 16 edges or deselect; the code counts the 16 edges only after a frame sync fall.
// R11 - Start or frame sync held high: inactive.
`timescale 1ns/10ps
`default_nettype none

module asfc_sample_frame_ctrl
	import asfc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       chipSelN,
	input  wire logic       serialClk,
	input  wire logic       serialDataIn,
	input  wire logic       sample_start_n,
	input  wire logic       frame_sync,
	input  wire logic [1:0] convMode,
	input  wire logic       readyAsInt,
	input  wire logic       convDone,
	output logic            samplingOn,
	output logic            convStartPulse,
	output logic            eocIntN,
	output logic            sdiEnable,
	output logic            sdiData
);

	logic                       csLevel;
	logic                       csRise;
	logic                       csFall;
	logic                       sclkRise;
	logic                       startLevelN;
	logic                       startRise;
	logic                       startFall;
	logic                       fsFall;
	asfc_phase_type             phase_q;
	logic                       pendStart_q;
	logic [2:0]                 selEdges_q;
	logic                       chanSel_q;
	logic [ASFC_EDGE_CNT_W-1:0] edgeCnt_q;
	logic                       fsFramed_q;
	logic                       sampleEnd;

	// Pin edge detection; chip select, start and frame sync idle high.
	asfc_edge_detect #(.RESET_LEVEL(1'b1)) uCs
	(
		.clk   (clk),
		.rstn  (rstn),
		.pinIn (chipSelN),
		.level (csLevel),
		.rise  (csRise),
		.fall  (csFall)
	);

	asfc_edge_detect #(.RESET_LEVEL(1'b0)) uSclk
	(
		.clk   (clk),
		.rstn  (rstn),
		.pinIn (serialClk),
		.level (),
		.rise  (sclkRise),
		.fall  ()
	);

	// R11 held high
	// Only edges act, so a start pin tied high never opens a window.
	asfc_edge_detect #(.RESET_LEVEL(1'b1)) uStart
	(
		.clk   (clk),
		.rstn  (rstn),
		.pinIn (sample_start_n),
		.level (startLevelN),
		.rise  (startRise),
		.fall  (startFall)
	);

	asfc_edge_detect #(.RESET_LEVEL(1'b1)) uFs
	(
		.clk   (clk),
		.rstn  (rstn),
		.pinIn (frame_sync),
		.level (),
		.rise  (),
		.fall  (fsFall)
	);

	// Sampling ends on the start pin rising while chip select is high.
	assign sampleEnd = (phase_q == ASFC_SAMPLE) && startRise && csLevel;

	// Count serial clock edges of a select cycle to know when the channel is set.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			selEdges_q <= 3'h0;
			chanSel_q  <= 1'b0;
		end
		else if (csFall)
		begin
			selEdges_q <= 3'h0;
			chanSel_q  <= 1'b0;
		end
		else if (!csLevel && sclkRise && !chanSel_q)
		begin
			selEdges_q <= selEdges_q + 3'h1;
			// R2 channel selected
			chanSel_q  <= (selEdges_q + 3'h1) == ASFC_CHAN_SEL_EDGE;
		end
	end

	// R3 deferred start
	// An early start in mode 01 is held until chip select returns high.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pendStart_q <= 1'b0;
		else if (csRise || startRise)
			pendStart_q <= 1'b0;
		else if (startFall && !csLevel && chanSel_q && convMode == ASFC_MODE_SELECT)
			pendStart_q <= 1'b1;
	end

	// Sample and conversion phase sequencing.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			phase_q <= ASFC_IDLE;
		else
		begin
			unique case (phase_q)
				ASFC_IDLE:
				begin
					// R1 window opens
					if (csLevel && startFall)
						phase_q <= ASFC_SAMPLE;
					// R3 deferred start
					else if (csRise && pendStart_q && !startLevelN)
						phase_q <= ASFC_SAMPLE;
				end
				ASFC_SAMPLE:
				begin
					// R1 window closes
					if (sampleEnd)
						phase_q <= ASFC_CONVERT;
				end
				ASFC_CONVERT:
				begin
					if (convDone)
						phase_q <= ASFC_IDLE;
				end
				default:
					phase_q <= ASFC_IDLE;
			endcase
		end
	end

	// The sampling output rises one cycle after the phase and drops with the phase at window end, straight from a flop.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			samplingOn <= 1'b0;
		else
			samplingOn <= (phase_q == ASFC_SAMPLE) && !sampleEnd;
	end

	// R4 conversion launch
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			convStartPulse <= 1'b0;
		else
			convStartPulse <= sampleEnd;
	end

	// Shared ready output: end-of-conversion level or interrupt falling edge.
	// The interrupt level releases when the host selects the device to read.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			eocIntN <= 1'b1;
		else if (readyAsInt)
		begin
			// R7 ready edge
			if (phase_q == ASFC_CONVERT && convDone)
				eocIntN <= 1'b0;
			else if (csFall)
				eocIntN <= 1'b1;
		end
		// R6 mode 00 only
		else if (convMode == ASFC_MODE_EOC)
		begin
			// R5 low until ready
			if (sampleEnd)
				eocIntN <= 1'b0;
			else if (phase_q == ASFC_CONVERT && convDone)
				eocIntN <= 1'b1;
		end
		else
			eocIntN <= 1'b1;
	end

	// Frame gating of the serial data input and its edge counter.
	// With frame sync tied high the frame follows chip select alone.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sdiEnable  <= 1'b0;
			fsFramed_q <= 1'b0;
			edgeCnt_q  <= ASFC_EDGE_CNT_RST;
		end
		// R10 deselect closes
		else if (csRise || csLevel)
		begin
			sdiEnable  <= 1'b0;
			fsFramed_q <= 1'b0;
		end
		// R9 frame sync fall
		else if (fsFall)
		begin
			sdiEnable  <= 1'b1;
			fsFramed_q <= 1'b1;
			edgeCnt_q  <= ASFC_EDGE_CNT_RST;
		end
		else if (csFall)
		begin
			// R8 wait for sync
			// R11 held high
			sdiEnable  <= frame_sync;
			fsFramed_q <= 1'b0;
		end
		else if (fsFramed_q && sdiEnable && sclkRise)
		begin
			edgeCnt_q <= edgeCnt_q + 4'h1;
			// R10 sixteen edges
			if (edgeCnt_q == ASFC_EDGE_CNT_MAX)
				sdiEnable <= 1'b0;
		end
	end

	// Serial data passes only while the input is enabled; otherwise it reads low.
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			sdiData <= 1'b0;
		else
			sdiData <= serialDataIn & sdiEnable;
	end

endmodule

`default_nettype wire

// >>> tb/asfc_sample_frame_ctrl_asserts.sv
// Port checks of the sample and frame control block.
`timescale 1ns/10ps
`default_nettype none
module asfc_sample_frame_ctrl_asserts
	import asfc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic       chipSelN,
	input wire logic       serialDataIn,
	input wire logic [1:0] convMode,
	input wire logic       readyAsInt,
	input wire logic       convDone,
	input wire logic       samplingOn,
	input wire logic       convStartPulse,
	input wire logic       eocIntN,
	input wire logic       sdiEnable,
	input wire logic       sdiData
);
	// All checks use the system clock and rest while reset is low.
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	property p_one; convStartPulse |=> !convStartPulse; endproperty
	a_one: assert property (p_one) else $error("start pulse too long");
	property p_end; convStartPulse |-> $fell(samplingOn); endproperty
	a_end: assert property (p_end) else $error("window open at start");
	property p_go; $fell(samplingOn) |-> convStartPulse; endproperty
	a_go: assert property (p_go) else $error("no start at window end");
	property p_eoc; convStartPulse && convMode == ASFC_MODE_EOC && !readyAsInt |-> !eocIntN; endproperty
	a_eoc: assert property (p_eoc) else $error("eoc not low");
	property p_noeoc; convStartPulse && convMode != ASFC_MODE_EOC && !readyAsInt |-> eocIntN; endproperty
	a_noeoc: assert property (p_noeoc) else $error("eoc outside mode 00");
	property p_int; readyAsInt && $fell(eocIntN) |-> $past(convDone); endproperty
	a_int: assert property (p_int) else $error("int without done");
	property p_cs; $rose(chipSelN) |-> ##[1:2] !sdiEnable; endproperty
	a_cs: assert property (p_cs) else $error("input on after deselect");
	property p_gate; sdiData == ($past(sdiEnable) & $past(serialDataIn)); endproperty
	a_gate: assert property (p_gate) else $error("data not gated");
endmodule
bind asfc_sample_frame_ctrl asfc_sample_frame_ctrl_asserts chk
(
	.clk            (clk),
	.rstn           (rstn),
	.chipSelN       (chipSelN),
	.serialDataIn   (serialDataIn),
	.convMode       (convMode),
	.readyAsInt     (readyAsInt),
	.convDone       (convDone),
	.samplingOn     (samplingOn),
	.convStartPulse (convStartPulse),
	.eocIntN        (eocIntN),
	.sdiEnable      (sdiEnable),
	.sdiData        (sdiData)
);
`default_nettype wire

// >>> tb/asfc_host_model.sv
// Host serial port model that drives the converter pins.
`timescale 1ns/10ps
`default_nettype none
module asfc_host_model
(
	input  wire logic clk,
	output logic      chipSelN,
	output logic      serialClk,
	output logic      serialDataIn,
	output logic      sample_start_n,
	output logic      frame_sync
);
	initial
		{chipSelN, serialClk, serialDataIn, sample_start_n, frame_sync} = 5'h13;
	task setStart(input logic v);
		@(posedge clk) sample_start_n <= v;
	endtask
	// Frame sync settles a cycle before select so the two never coincide.
	task selFs(input logic v);
		@(posedge clk) frame_sync <= v;
		@(posedge clk) chipSelN <= 1'b0;
	endtask
	task fsFall();
		@(posedge clk) frame_sync <= 1'b1;
		@(posedge clk) frame_sync <= 1'b0;
	endtask
	// Data moves on the falling serial edge, so it is steady at each rise.
	task clocks(input int n);
		repeat (n)
		begin
			@(posedge clk) serialClk <= 1'b1;
			@(posedge clk) serialClk <= 1'b0;
			serialDataIn <= ~serialDataIn;
		end
	endtask
	task desel();
		@(posedge clk) chipSelN <= 1'b1;
		frame_sync <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_adc_sample_frame_control.sv
// Self-checking bench of the sample and frame control block.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_sample_frame_control;
	import asfc_pkg::*;
	typedef struct {logic [1:0] m; logic i; logic e0; logic e1;} asfc_row_type;
	logic clk, rstn, chipSelN, serialClk, serialDataIn, sample_start_n, frame_sync, readyAsInt, convDone;
	logic [1:0] convMode;
	logic samplingOn, convStartPulse, eocIntN, sdiEnable, sdiData;
	int fail_count, num_checks, cyc, w;
	asfc_row_type rows [5] = '{'{2'h0, 1'b0, 1'b0, 1'b1}, '{2'h1, 1'b0, 1'b1, 1'b1},
		'{2'h0, 1'b1, 1'b1, 1'b0}, '{2'h1, 1'b1, 1'b1, 1'b0}, '{2'h2, 1'b0, 1'b1, 1'b1}};
	asfc_sample_frame_ctrl uut
	(
		.clk            (clk),
		.rstn           (rstn),
		.chipSelN       (chipSelN),
		.serialClk      (serialClk),
		.serialDataIn   (serialDataIn),
		.sample_start_n (sample_start_n),
		.frame_sync     (frame_sync),
		.convMode       (convMode),
		.readyAsInt     (readyAsInt),
		.convDone       (convDone),
		.samplingOn     (samplingOn),
		.convStartPulse (convStartPulse),
		.eocIntN        (eocIntN),
		.sdiEnable      (sdiEnable),
		.sdiData        (sdiData)
	);
	asfc_host_model host
	(
		.clk            (clk),
		.chipSelN       (chipSelN),
		.serialClk      (serialClk),
		.serialDataIn   (serialDataIn),
		.sample_start_n (sample_start_n),
		.frame_sync     (frame_sync)
	);
	task chk(input string n, input logic [4:0] seen, input logic [4:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task end_sim();
		if (fail_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task done();
		@(posedge clk) convDone <= 1'b1;
		@(posedge clk) convDone <= 1'b0;
		@(posedge clk);
		@(negedge clk);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// The run needs some 160 cycles; far beyond that it has hung.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			end_sim();
		end
	end
	// Reset, mode table, then deferred start and frame gating.
	initial
	begin
		rstn = 1'b0;
		convMode = 2'h0;
		readyAsInt = 1'b0;
		convDone = 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk("reset", {samplingOn, convStartPulse, eocIntN, sdiEnable, sdiData}, 5'h04);
		@(posedge clk) rstn <= 1'b1;
		foreach (rows[k])
		begin
			@(posedge clk) convMode <= rows[k].m;
			readyAsInt <= rows[k].i;
			host.setStart(1'b0);
			repeat (4) @(posedge clk);
			host.setStart(1'b1);
			w = 0;
			while (convStartPulse !== 1'b1 && w < 8)
			begin
				@(negedge clk);
				w++;
			end
			chk("start", convStartPulse, 1'b1);
			chk("eoc start", eocIntN, rows[k].e0);
			done();
			chk("eoc done", eocIntN, rows[k].e1);
			host.selFs(1'b1);
			host.desel();
			repeat (2) @(negedge clk);
			chk("eoc idle", eocIntN, 1'b1);
		end
		// start only after the fifth clock
		@(posedge clk) convMode <= ASFC_MODE_SELECT;
		readyAsInt <= 1'b0;
		host.selFs(1'b1);
		host.clocks(5);
		host.setStart(1'b0);
		repeat (3) @(negedge clk);
		chk("held", samplingOn, 1'b0);
		chk("spi", sdiEnable, 1'b1);
		host.desel();
		repeat (4) @(negedge clk);
		chk("deferred", samplingOn, 1'b1);
		host.setStart(1'b1);
		repeat (3) @(negedge clk);
		chk("closed", samplingOn, 1'b0);
		done();
		host.selFs(1'b0);
		repeat (3) @(negedge clk);
		chk("fs low", sdiEnable, 1'b0);
		chk("data off", sdiData, 1'b0);
		host.fsFall();
		repeat (3) @(negedge clk);
		chk("fs fall", sdiEnable, 1'b1);
		chk("data on", sdiData, 1'b1);
		host.clocks(15);
		repeat (2) @(negedge clk);
		chk("15 edges", sdiEnable, 1'b1);
		host.clocks(1);
		repeat (3) @(negedge clk);
		chk("16 edges", sdiEnable, 1'b0);
		chk("data gated", sdiData, 1'b0);
		host.desel();
		// Reset in mid-window: every output takes its reset value at once, and idle pins make no edge after release.
		host.setStart(1'b0);
		repeat (3) @(negedge clk);
		chk("window", samplingOn, 1'b1);
		@(posedge clk) rstn <= 1'b0;
		host.setStart(1'b1);
		@(negedge clk);
		chk("reset mid", {samplingOn, convStartPulse, eocIntN, sdiEnable, sdiData}, 5'h04);
		@(posedge clk) rstn <= 1'b1;
		repeat (2) @(negedge clk);
		chk("after reset", {samplingOn, convStartPulse, eocIntN, sdiEnable, sdiData}, 5'h04);
		end_sim();
	end
endmodule
`default_nettype wire
